// >>> rtcsc_counter.sv
// Seconds and subsecond time counter with its serial register port.
`timescale 1ns/1ns
// Summary of operation
// - Seconds count is a plain 32-bit binary up-counter, one step per second.
// - Subsecond counts 00 to ff, wraps to 00, and the wrap bumps seconds.
// - Subsecond steps on a 256 Hz tick divided down from the 32 kHz crystal.
// - With run enabled, counting never pauses for serial reads or writes.
// - Time writes are ignored unless the write unlock bit was set earlier.
// - Time write is one 40-bit burst, seconds bit 31 first, subsecond bit 0 last.
// - Chip select lifted before the 40th rising edge discards the time write.
// - Counters load the shifted value on the rising edge of the 40th bit.
// - Time read is a 40-bit burst, seconds bit 31 first, subsecond bit 0 last.
// - A read may end early; bits already shifted out stay correct.
// - Decoding a read command latches a stable snapshot that is shifted out.
// - Reported time may trail the true count by at most one second.
// - Seconds and subsecond counters are zero after power-on.
// - Unlock takes effect after the 16th clock, not for run enable in same write.
// - Run enable is set after power-on; clearing it stops the counters.
module rtcsc_counter
	import rtcsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic xtal_clk,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	output logic [31:0] seconds_count,
	output logic [7:0] subsecond,
	output logic clock_run_enable,
	output logic time_write_unlock
);
	rtcsc_regs_t r;
	rtcsc_regs_t next_r;
	logic xtal_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	logic [7:0] cmd_byte;
	logic [15:0] ctrl_word;
	logic [39:0] time_word;
	logic [15:0] ctrl_view;

	always_comb
	begin
		next_r = r;
		// Only the second stage reads the first stage; the edge register reads the second stage.
		next_r.sync1 = {xtal_clk, sclk, cs_n, sdi};
		next_r.sync2 = r.sync1;
		next_r.prev = r.sync2;
		// The crystal is sampled like any pin; only its rising edges move the prescaler.
		xtal_rise = r.sync2[RTCSC_LANE_XTAL] & ~r.prev[RTCSC_LANE_XTAL];
		sclk_rise = r.sync2[RTCSC_LANE_SCLK] & ~r.prev[RTCSC_LANE_SCLK];
		sclk_fall = ~r.sync2[RTCSC_LANE_SCLK] & r.prev[RTCSC_LANE_SCLK];
		cs_active = ~r.sync2[RTCSC_LANE_CSN];
		cmd_byte = {r.rx[6:0], r.sync2[RTCSC_LANE_DIN]};
		ctrl_word = {r.rx[14:0], r.sync2[RTCSC_LANE_DIN]};
		time_word = {r.rx[38:0], r.sync2[RTCSC_LANE_DIN]};
		ctrl_view = 16'h0000;
		ctrl_view[RTCSC_CTRL_UNLOCK_POS] = r.time_write_unlock;
		ctrl_view[RTCSC_CTRL_RUN_POS] = r.clock_run_enable;

		// Counting runs regardless of serial activity.
		if (r.clock_run_enable && xtal_rise)
		begin
			if (r.prescale == RTCSC_PRESCALE_LAST)
			begin
				next_r.prescale = 7'h00;
				next_r.subsecond = r.subsecond + 8'h01;
				if (r.subsecond == RTCSC_SUBSEC_LAST)
				begin
					next_r.seconds_count = r.seconds_count + 32'h0000_0001;
				end
			end
			else
			begin
				next_r.prescale = r.prescale + 7'h01;
			end
		end

		if (!cs_active)
		begin
			// Dropping select abandons any partial frame without touching the counters.
			next_r.state = RTCSC_ST_CMD;
			next_r.bit_cnt = 6'h00;
			next_r.sdo_oe = 1'b0;
		end
		else if (sclk_rise)
		begin
			next_r.rx = time_word;
			next_r.bit_cnt = r.bit_cnt + 6'h01;
			case (r.state)
				RTCSC_ST_CMD:
				begin
					if (r.bit_cnt == RTCSC_CMD_LAST_BIT)
					begin
						next_r.bit_cnt = 6'h00;
						if (cmd_byte[7:1] == RTCSC_ADDR_TIME)
						begin
							if (cmd_byte[0])
							begin
								// Snapshot is the counter state at decode; a later tick cannot
								// tear it, at the cost of up to one second of staleness.
								next_r.tx = {r.seconds_count, r.subsecond};
								next_r.state = RTCSC_ST_READ;
							end
							else
							begin
								next_r.state = RTCSC_ST_WR_TIME;
							end
						end
						else if (cmd_byte[7:1] == RTCSC_ADDR_CTRL)
						begin
							next_r.tx = {ctrl_view, 24'h000000};
							if (cmd_byte[0])
							begin
								next_r.state = RTCSC_ST_READ;
							end
							else
							begin
								next_r.state = RTCSC_ST_WR_CTRL;
							end
						end
						else
						begin
							next_r.state = RTCSC_ST_SKIP;
						end
					end
				end
				RTCSC_ST_WR_CTRL:
				begin
					if (r.bit_cnt == RTCSC_CTRL_LAST_BIT)
					begin
						// Run enable is gated by the unlock value from before this frame.
						if (r.time_write_unlock)
						begin
							next_r.clock_run_enable = ctrl_word[RTCSC_CTRL_RUN_POS];
						end
						next_r.time_write_unlock = ctrl_word[RTCSC_CTRL_UNLOCK_POS];
						next_r.state = RTCSC_ST_SKIP;
					end
				end
				RTCSC_ST_WR_TIME:
				begin
					if (r.bit_cnt == RTCSC_TIME_LAST_BIT)
					begin
						if (r.time_write_unlock)
						begin
							// Load overrides any tick in the same cycle.
							next_r.seconds_count = time_word[39:8];
							next_r.subsecond = time_word[7:0];
							next_r.prescale = 7'h00;
						end
						next_r.state = RTCSC_ST_SKIP;
					end
				end
				RTCSC_ST_READ:
				begin
					// Read bits are paced by the falling edges; a rise only samples the line.
					next_r.bit_cnt = r.bit_cnt;
				end
				RTCSC_ST_SKIP:
				begin
					// Clocks after a finished or refused frame are ignored.
					next_r.bit_cnt = r.bit_cnt;
				end
				default:
				begin
					next_r.state = RTCSC_ST_SKIP;
					next_r.bit_cnt = r.bit_cnt;
				end
			endcase
		end
		else if (sclk_fall && r.state == RTCSC_ST_READ)
		begin
			// Each bit is presented on the falling edge so the host samples it on the rise.
			next_r.sdo = r.tx[39];
			next_r.tx = {r.tx[38:0], 1'b0};
			next_r.sdo_oe = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			// Synchronisers start at the select idle level so release never opens a frame.
			r <= '{
				sync1: 4'hf,
				sync2: 4'hf,
				prev: 4'hf,
				prescale: 7'h00,
				subsecond: RTCSC_SUBSEC_RESET,
				seconds_count: RTCSC_SECONDS_RESET,
				time_write_unlock: RTCSC_UNLOCK_RESET,
				clock_run_enable: RTCSC_RUN_RESET,
				state: RTCSC_ST_CMD,
				bit_cnt: 6'h00,
				rx: 40'h00_0000_0000,
				tx: 40'h00_0000_0000,
				sdo: 1'b0,
				sdo_oe: 1'b0
			};
		end
		else
		begin
			r <= next_r;
		end
	end

	assign sdo = r.sdo;
	assign sdo_oe = r.sdo_oe;
	assign seconds_count = r.seconds_count;
	assign subsecond = r.subsecond;
	assign clock_run_enable = r.clock_run_enable;
	assign time_write_unlock = r.time_write_unlock;
endmodule

// >>> rtcsc_pkg.sv
// Package with constants, states and the state record of the seconds counter block.
package rtcsc_pkg;
	// Crystal and prescaler timing.
	localparam int RTCSC_XTAL_HZ = 32768;
	localparam int RTCSC_TICK_HZ = 256;
	localparam int RTCSC_PRESCALE_DIV = RTCSC_XTAL_HZ / RTCSC_TICK_HZ;
	localparam logic [6:0] RTCSC_PRESCALE_LAST = 7'(RTCSC_PRESCALE_DIV - 1);
	localparam logic [7:0] RTCSC_SUBSEC_LAST = 8'hff;
	// Serial frame layout.
	localparam logic [5:0] RTCSC_CMD_LAST_BIT = 6'h07;
	localparam logic [5:0] RTCSC_CTRL_LAST_BIT = 6'h0f;
	localparam logic [5:0] RTCSC_TIME_LAST_BIT = 6'h27;
	// Register addresses carried in the upper seven bits of the command byte.
	localparam logic [6:0] RTCSC_ADDR_CTRL = 7'h10;
	localparam logic [6:0] RTCSC_ADDR_TIME = 7'h11;
	// Field positions inside the 16-bit control word.
	localparam int RTCSC_CTRL_UNLOCK_POS = 12;
	localparam int RTCSC_CTRL_RUN_POS = 11;
	// Values after reset.
	localparam logic [31:0] RTCSC_SECONDS_RESET = 32'h0000_0000;
	localparam logic [7:0] RTCSC_SUBSEC_RESET = 8'h00;
	localparam logic RTCSC_UNLOCK_RESET = 1'b0;
	localparam logic RTCSC_RUN_RESET = 1'b1;
	// Pin synchroniser lanes.
	localparam int RTCSC_LANE_DIN = 0;
	localparam int RTCSC_LANE_CSN = 1;
	localparam int RTCSC_LANE_SCLK = 2;
	localparam int RTCSC_LANE_XTAL = 3;

	typedef enum logic [4:0] {
		RTCSC_ST_CMD = 5'b00001,
		RTCSC_ST_WR_CTRL = 5'b00010,
		RTCSC_ST_WR_TIME = 5'b00100,
		RTCSC_ST_READ = 5'b01000,
		RTCSC_ST_SKIP = 5'b10000
	} rtcsc_state_t;

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] prev;
		logic [6:0] prescale;
		logic [7:0] subsecond;
		logic [31:0] seconds_count;
		logic time_write_unlock;
		logic clock_run_enable;
		rtcsc_state_t state;
		logic [5:0] bit_cnt;
		logic [39:0] rx;
		logic [39:0] tx;
		logic sdo;
		logic sdo_oe;
	} rtcsc_regs_t;
endpackage

// >>> rtcsc_counter_props.sv
// Port checker of the time counter block.
`timescale 1ns/1ns
module rtcsc_counter_props
	import rtcsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic xtal_clk,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic [31:0] seconds_count,
	input wire logic [7:0] subsecond,
	input wire logic clock_run_enable,
	input wire logic time_write_unlock
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Idle link means only a subsecond wrap may move the seconds.
	wrap_carry_a: assert property (cs_n && $past(cs_n, 6) && $changed(seconds_count) |->
		seconds_count == $past(seconds_count) + 32'h1 && $past(subsecond) == 8'hff
		&& subsecond == 8'h00) else $error("seconds moved without a wrap");
	sub_step_a: assert property (cs_n && $past(cs_n, 6) && $changed(subsecond) |->
		subsecond == $past(subsecond) + 8'h01 && clock_run_enable) else $error("bad step");
	halt_hold_a: assert property (!clock_run_enable && $past(cs_n, 2) |->
		$stable(subsecond) && $stable(seconds_count)) else $error("counted while halted");
	oe_release_a: assert property (cs_n [*5] |-> !sdo_oe) else $error("sdo kept driven");
	cfg_in_frame_a: assert property ($changed({time_write_unlock, clock_run_enable}) |->
		!$past(cs_n, 2)) else $error("control bit moved outside a frame");
	run_after_unlock_a: assert property ($changed(clock_run_enable) |->
		$past(time_write_unlock)) else $error("run bit changed while locked");
	load_unlocked_a: assert property ($changed(seconds_count) &&
		seconds_count != $past(seconds_count) + 32'h1 |-> time_write_unlock
		&& !$past(cs_n, 2)) else $error("time loaded while locked");
	sdo_on_fall_a: assert property (sdo_oe && $changed(sdo) |-> !$past(sclk, 2))
		else $error("sdo changed away from a falling edge");
endmodule
bind rtcsc_counter rtcsc_counter_props u_props (.clk(clk), .rst(rst), .xtal_clk(xtal_clk),
	.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
	.seconds_count(seconds_count), .subsecond(subsecond),
	.clock_run_enable(clock_run_enable), .time_write_unlock(time_write_unlock));

// >>> rtcsc_host.sv
// Host model that clocks frames over the serial link.
`timescale 1ns/1ns
module rtcsc_host (
	input wire logic clk,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	logic [55:0] rx = 56'h0;
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// A full frame lasts about 20 us, well inside the 1 ms read limit.
	// One link period is eight system clocks, four low and four high, so a bit
	// presented two clocks after a fall is settled when it is sampled on the rise.
	task automatic xfer(input int n, input logic [55:0] tx);
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			repeat (2) @(posedge clk);
			sdi <= tx[55 - i];
			repeat (2) @(posedge clk);
			sclk <= 1'b1;
			rx <= {rx[54:0], sdo};
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
		sdi <= ~sdi;
		repeat (8) @(posedge clk);
	endtask
endmodule

// >>> tb.sv
// Testbench of the time counter block.
`timescale 1ns/1ns
module tb
	import rtcsc_pkg::*;
();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic xtal_clk = 1'b0;
	logic xtal_on = 1'b0;
	logic cs_n, sclk, sdi, sdo, sdo_oe, run, unlock;
	logic [31:0] sec;
	logic [7:0] sub;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	rtcsc_counter u_dut (.clk(clk), .rst(rst), .xtal_clk(xtal_clk), .cs_n(cs_n), .sclk(sclk),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .seconds_count(sec), .subsecond(sub),
		.clock_run_enable(run), .time_write_unlock(unlock));
	rtcsc_host u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("Mismatches %0d, comparisons %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [39:0] d, input int n);
		u_host.xfer(n, {a, 1'b0, d, 8'h00});
		repeat (4) @(posedge clk);
	endtask
	// A 200 ns crystal keeps a subsecond tick at 512 clocks.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles[0])
			xtal_clk <= xtal_on & ~xtal_clk;
		if (cycles == 20000)
		begin
			err_total++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({sec, sub}, 40'h0);
		chk({38'h0, run, unlock}, 40'h2);
		wr(RTCSC_ADDR_TIME, 40'h12345678fe, 48);
		chk({sec, sub}, 40'h0);
		wr(RTCSC_ADDR_CTRL, 40'h1000000000, 24);
		chk({38'h0, run, unlock}, 40'h3);
		wr(RTCSC_ADDR_CTRL, 40'h1000000000, 24);
		chk({38'h0, run, unlock}, 40'h1);
		wr(RTCSC_ADDR_TIME, 40'h12345678fe, 48);
		chk({sec, sub}, 40'h12345678fe);
		wr(RTCSC_ADDR_TIME, 40'h0, 47);
		wr(7'h05, 40'h1800000000, 24);
		xtal_on <= 1'b1;
		repeat (600) @(posedge clk);
		chk({sec, sub}, 40'h12345678fe);
		chk({38'h0, run, unlock}, 40'h1);
		wr(RTCSC_ADDR_CTRL, 40'h1800000000, 24);
		repeat (1200) @(posedge clk);
		chk({sec, sub}, 40'h1234567900);
		u_host.xfer(48, {RTCSC_ADDR_TIME, 1'b1, 48'h0});
		chk(u_host.rx[39:0], 40'h1234567900);
		chk({sec, sub}, 40'h1234567901);
		u_host.xfer(20, {RTCSC_ADDR_TIME, 1'b1, 48'h0});
		chk({28'h0, u_host.rx[11:0]}, 40'h123);
		chk({39'h0, sdo_oe}, 40'h0);
		u_host.xfer(24, {RTCSC_ADDR_CTRL, 1'b1, 48'h0});
		chk({24'h0, u_host.rx[15:0]}, 40'h1800);
		end_of_test();
	end
endmodule
